/* File: include/stam_pkg.sv */
// Package with register map, fields and resets of the sync/alarm slice
package stam_pkg;
  localparam logic [6:0] OFS_ALIGN_CTRL = 7'h5b;
  localparam logic [6:0] OFS_TIMER_LOW = 7'h5c;
  localparam logic [6:0] OFS_TIMER_HIGH = 7'h5d;
  localparam logic [6:0] OFS_TIMER_MISC = 7'h5e;
  localparam logic [6:0] OFS_EXT_OSC_CTRL = 7'h64;
  localparam logic [6:0] OFS_DELAY_COMMON = 7'h65;
  localparam logic [6:0] OFS_FIRST_MASK = 7'h70;
  localparam logic [6:0] OFS_GENERAL_MASK = 7'h71;
  localparam logic [6:0] OFS_PART_ID_LOW = 7'h78;
  localparam logic [6:0] OFS_PART_ID_MID = 7'h79;
  localparam logic [6:0] OFS_PART_ID_HIGH = 7'h7a;
  localparam logic [6:0] OFS_ALARM_READBACK = 7'h7b;
  localparam int BIT_RETIME = 2;
  localparam int BIT_RESEED_LOOP2 = 1;
  localparam int BIT_POLARITY = 0;
  localparam int BIT_DIV2 = 1;
  localparam int BIT_LOW_FREQ = 0;
  localparam int BIT_LOW_POWER = 0;
  localparam int TIMER_W = 12;
  localparam int TIMER_HIGH_W = 4;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [TIMER_W-1:0] RESET_TIMER = 12'h000;
  // Arbitrary neutral identifier value
  localparam logic [23:0] PART_ID_DEFAULT = 24'h00_0000;
endpackage

/* File: hw/stam_regs.sv */
// Sync, master timer, oscillator, delay and alarm mask register slice
// What this block does
// R1: Bit 2 selects retime through reference zero
// R2: Bit 1 routes reseed through second loop
// R3: Bit 0 picks request edge polarity
// R4: Twelve-bit timer setpoint across two registers
// R5: Setpoint sets master timer beat period
// R6: Software keeps beat slow and submultiple
// R7: Oscillator divide-by-two and low-frequency bias bits
// R8: Bit 0 selects low-power analog delay
// R9: First-loop status masks on bits 7:4
// R10: Per-input loss-of-signal masks bits 3:0
// R11: General masks for five alarm sources
// R12: Read-only 24-bit part identifier
// R13: Readback bit 0 shows combined alarm
// R14: Sync request when second loop locked or disabled, unsynced
// R15: Near lock at one sixteenth limit
// R16: Alarm is OR of masked sources
// R17: Reserved bits store but do nothing
`timescale 1ns/1ps
module stam_regs
  import stam_pkg::*;
#(
  parameter logic [23:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic align_req,
  input wire logic ref_zero_clk_tick,
  input wire logic first_loop_count_hit,
  input wire logic first_loop_acquiring,
  input wire logic first_loop_locked,
  input wire logic first_loop_holdover,
  input wire logic [3:0] input_los,
  input wire logic second_loop_locked,
  input wire logic second_loop_disabled,
  input wire logic outputs_synced,
  input wire logic output_phase_status,
  input wire logic sysref_sync_status,
  output logic [7:0] rd_data,
  output logic align_event,
  output logic reseed_via_second_loop,
  output logic master_beat,
  output logic oscillator_div2,
  output logic oscillator_low_freq,
  output logic delay_low_power,
  output logic alarm
);
  typedef struct packed {
    logic [7:0] align_ctrl;
    logic [TIMER_W-1:0] timer;
    logic [3:0] timer_hi_rsvd;
    logic [7:0] timer_misc;
    logic [7:0] ext_osc;
    logic [7:0] delay_common;
    logic [7:0] first_mask;
    logic [7:0] general_mask;
    logic [1:0] req_sync;
    logic [1:0] st_sync;
    logic req_prev;
    logic req_held;
    logic [TIMER_W-1:0] beat_cnt;
    logic [7:0] rd_data;
    logic align_event;
    logic master_beat;
    logic alarm;
  } stam_state_s;

  stam_state_s q;
  stam_state_s d;
  logic [11:0] src_sync;
  logic [11:0] src_raw;
  logic [7:0] first_src;
  logic [4:0] gen_src;
  logic req_lvl;
  logic req_edge;
  logic next_alarm;

  // Status inputs come from other clock domains: two flops each
  assign src_raw = {first_loop_count_hit, first_loop_acquiring,
                    first_loop_locked, first_loop_holdover, input_los,
                    second_loop_locked, second_loop_disabled,
                    outputs_synced, output_phase_status};
  logic [11:0] src_meta;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_meta <= 12'h000;
      src_sync <= 12'h000;
    end else begin
      src_meta <= src_raw;
      src_sync <= src_meta;
    end
  end
  logic sync_stat_meta;
  logic sync_stat;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_stat_meta <= 1'b0;
      sync_stat <= 1'b0;
    end else begin
      sync_stat_meta <= sysref_sync_status;
      sync_stat <= sync_stat_meta;
    end
  end

  always_comb begin
    // Near lock comes from the 1/16 counter compare in the loop
    first_src = {src_sync[11:4]}; // R15
    gen_src[4] = (src_sync[3] | src_sync[2]) & ~src_sync[1]; // R14
    gen_src[3] = src_sync[9] & src_sync[3];
    gen_src[2] = src_sync[0];
    gen_src[1] = sync_stat;
    gen_src[0] = src_sync[3];
    next_alarm = |(first_src & q.first_mask) // R9 R10 R16
      | |(gen_src & q.general_mask[4:0]); // R11 R16
  end

  always_comb begin
    d = q;
    req_lvl = q.req_sync[1];
    // Edge taken on the synchronized level: a polarity write makes no false edge
    req_edge = q.align_ctrl[BIT_POLARITY] ? (~req_lvl & q.req_prev) // R3
      : (req_lvl & ~q.req_prev);
    d.req_sync = {q.req_sync[0], align_req};
    d.req_prev = req_lvl;
    d.align_event = 1'b0;
    if (q.align_ctrl[BIT_RETIME]) begin // R1
      // Retime: hold the edge until the next reference zero tick
      if (req_edge)
        d.req_held = 1'b1;
      if ((q.req_held | req_edge) && q.st_sync[1]) begin
        d.align_event = 1'b1;
        d.req_held = 1'b0;
      end
    end else begin
      d.req_held = 1'b0;
      d.align_event = req_edge;
    end
    d.st_sync = {q.st_sync[0], ref_zero_clk_tick};
    // Beat period is setpoint+1 cycles; zero gives a beat every cycle
    d.master_beat = 1'b0;
    if (q.beat_cnt >= q.timer) begin // R5
      d.beat_cnt = '0;
      d.master_beat = 1'b1;
    end else begin
      d.beat_cnt = q.beat_cnt + 12'h001;
    end
    if (wr_en) begin
      unique case (addr)
        OFS_ALIGN_CTRL: d.align_ctrl = wr_data; // R17
        OFS_TIMER_LOW: d.timer[7:0] = wr_data; // R4
        OFS_TIMER_HIGH: begin
          d.timer[TIMER_W-1:8] = wr_data[TIMER_HIGH_W-1:0]; // R4
          d.timer_hi_rsvd = wr_data[7:4]; // R17
        end
        OFS_TIMER_MISC: d.timer_misc = wr_data;
        OFS_EXT_OSC_CTRL: d.ext_osc = wr_data; // R7
        OFS_DELAY_COMMON: d.delay_common = wr_data; // R8
        OFS_FIRST_MASK: d.first_mask = wr_data; // R9 R10
        OFS_GENERAL_MASK: d.general_mask = wr_data; // R11
        default: ;
      endcase
    end
    d.rd_data = q.rd_data;
    if (rd_en) begin
      unique case (addr)
        OFS_ALIGN_CTRL: d.rd_data = q.align_ctrl;
        OFS_TIMER_LOW: d.rd_data = q.timer[7:0];
        OFS_TIMER_HIGH: d.rd_data = {q.timer_hi_rsvd, q.timer[11:8]};
        OFS_TIMER_MISC: d.rd_data = q.timer_misc;
        OFS_EXT_OSC_CTRL: d.rd_data = q.ext_osc;
        OFS_DELAY_COMMON: d.rd_data = q.delay_common;
        OFS_FIRST_MASK: d.rd_data = q.first_mask;
        OFS_GENERAL_MASK: d.rd_data = q.general_mask;
        OFS_PART_ID_LOW: d.rd_data = PART_ID[7:0]; // R12
        OFS_PART_ID_MID: d.rd_data = PART_ID[15:8]; // R12
        OFS_PART_ID_HIGH: d.rd_data = PART_ID[23:16]; // R12
        OFS_ALARM_READBACK: d.rd_data = {7'h00, q.alarm}; // R13
        default: d.rd_data = 8'h00;
      endcase
    end
    d.alarm = next_alarm; // R16
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  logic div2_q;
  logic lowf_q;
  logic lowp_q;
  logic reseed_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div2_q <= 1'b0;
      lowf_q <= 1'b0;
      lowp_q <= 1'b0;
      reseed_q <= 1'b0;
    end else begin
      div2_q <= d.ext_osc[BIT_DIV2]; // R7
      lowf_q <= d.ext_osc[BIT_LOW_FREQ]; // R7
      // Low-power delay is not glitch-free between setpoints
      lowp_q <= d.delay_common[BIT_LOW_POWER]; // R8
      reseed_q <= d.align_ctrl[BIT_RESEED_LOOP2]; // R2
    end
  end

  assign rd_data = q.rd_data;
  assign align_event = q.align_event;
  assign master_beat = q.master_beat;
  assign alarm = q.alarm;
  assign oscillator_div2 = div2_q;
  assign oscillator_low_freq = lowf_q;
  assign delay_low_power = lowp_q;
  assign reseed_via_second_loop = reseed_q;

  property p_readback_alarm;
    @(posedge clk_sys) disable iff (rst)
      (rd_en && addr == OFS_ALARM_READBACK) |=>
        rd_data == {7'h00, $past(alarm)};
  endproperty
  a_readback_alarm: assert property (p_readback_alarm) // R13
    else $error("alarm readback mismatch");

  property p_part_id;
    @(posedge clk_sys) disable iff (rst)
      (rd_en && addr == OFS_PART_ID_HIGH) |=> rd_data == PART_ID[23:16];
  endproperty
  a_part_id: assert property (p_part_id) // R12
    else $error("part identifier high byte wrong");

  property p_timer_write;
    @(posedge clk_sys) disable iff (rst)
      (wr_en && addr == OFS_TIMER_HIGH) |=>
        q.timer[11:8] == $past(wr_data[3:0]);
  endproperty
  a_timer_write: assert property (p_timer_write) // R4
    else $error("timer high nibble not stored");

  sequence s_beat_due;
    q.beat_cnt >= q.timer;
  endsequence
  property p_beat_period;
    @(posedge clk_sys) disable iff (rst)
      s_beat_due |=> master_beat && q.beat_cnt == 12'h000;
  endproperty
  a_beat_period: assert property (p_beat_period) // R5
    else $error("master beat period wrong");

  property p_beat_quiet;
    @(posedge clk_sys) disable iff (rst)
      (q.beat_cnt < q.timer) |=>
        !master_beat && q.beat_cnt == $past(q.beat_cnt) + 12'h001;
  endproperty
  a_beat_quiet: assert property (p_beat_quiet) // R5
    else $error("master beat came early");

  property p_mask_zero;
    @(posedge clk_sys) disable iff (rst)
      (q.first_mask == 8'h00 && q.general_mask == 8'h00 && !wr_en) |=> !alarm;
  endproperty
  a_mask_zero: assert property (p_mask_zero) // R16
    else $error("alarm with all masks clear");

  property p_los_alarm;
    @(posedge clk_sys) disable iff (rst)
      (q.first_mask[0] && src_sync[4]) |=> alarm;
  endproperty
  a_los_alarm: assert property (p_los_alarm) // R10
    else $error("masked loss of signal missed");

  property p_bypass;
    @(posedge clk_sys) disable iff (rst)
      (!q.align_ctrl[BIT_RETIME] && req_edge) |=> align_event;
  endproperty
  a_bypass: assert property (p_bypass) // R1
    else $error("bypassed request not passed");

  property p_reseed;
    @(posedge clk_sys) disable iff (rst)
      (wr_en && addr == OFS_ALIGN_CTRL) |=>
        reseed_via_second_loop == $past(wr_data[BIT_RESEED_LOOP2]);
  endproperty
  a_reseed: assert property (p_reseed) // R2
    else $error("reseed routing not updated");

  sequence s_retime_pending;
    q.align_ctrl[BIT_RETIME] && (q.req_held || req_edge);
  endsequence
  property p_retime_fire;
    @(posedge clk_sys) disable iff (rst)
      s_retime_pending ##0 q.st_sync[1] |=> align_event;
  endproperty
  a_retime_fire: assert property (p_retime_fire) // R1
    else $error("retimed request not released on tick");

  property p_retime_wait;
    @(posedge clk_sys) disable iff (rst)
      s_retime_pending ##0 !q.st_sync[1] |=> !align_event && q.req_held;
  endproperty
  a_retime_wait: assert property (p_retime_wait) // R1
    else $error("retimed request not held for tick");

  property p_bypass_quiet;
    @(posedge clk_sys) disable iff (rst)
      (!q.align_ctrl[BIT_RETIME] && !req_edge) |=> !align_event;
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet) // R1
    else $error("align event without request edge");

  property p_osc_bits;
    @(posedge clk_sys) disable iff (rst)
      (wr_en && addr == OFS_EXT_OSC_CTRL) |=>
        oscillator_div2 == $past(wr_data[BIT_DIV2]) &&
        oscillator_low_freq == $past(wr_data[BIT_LOW_FREQ]);
  endproperty
  a_osc_bits: assert property (p_osc_bits) // R7
    else $error("oscillator controls not updated");

  property p_low_power;
    @(posedge clk_sys) disable iff (rst)
      (wr_en && addr == OFS_DELAY_COMMON) |=>
        delay_low_power == $past(wr_data[BIT_LOW_POWER]);
  endproperty
  a_low_power: assert property (p_low_power) // R8
    else $error("delay low power not updated");

  property p_sync_request;
    @(posedge clk_sys) disable iff (rst)
      (q.general_mask[4] && src_sync[2] && !src_sync[1]) |=> alarm;
  endproperty
  a_sync_request: assert property (p_sync_request) // R14
    else $error("sync request alarm missed");

  property p_lock_pair;
    @(posedge clk_sys) disable iff (rst)
      (q.general_mask[3] && src_sync[9] && src_sync[3]) |=> alarm;
  endproperty
  a_lock_pair: assert property (p_lock_pair) // R11
    else $error("combined lock alarm missed");

  property p_near_lock;
    @(posedge clk_sys) disable iff (rst)
      (q.first_mask[7] && src_sync[11]) |=> alarm;
  endproperty
  a_near_lock: assert property (p_near_lock) // R15
    else $error("near lock alarm missed");

endmodule // stam_regs

/* File: verif/stam_host.sv */
// Host processor model driving the register access strobes
`timescale 1ns/1ps
module stam_host (
  input wire logic clk_sys,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 7'h00;
    wr_data = 8'h00;
  end
  // Callers keep polarity 0 when reference zero is the source
  // Callers keep the beat slow, well under 4 MHz
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clk_sys) #1;
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  // Extra edge so the sample never races the read register
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys) #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk_sys) #1;
    rd_en = 1'b0;
    addr = ~a;
    @(posedge clk_sys) #1;
    d = rd_data;
  endtask
endmodule // stam_host

/* File: verif/tb_stam_regs.sv */
// Self-checking bench for the sync and alarm register slice
`timescale 1ns/1ps
module tb_stam_regs;
  import stam_pkg::*;
  // Arbitrary identifier value
  localparam logic [23:0] ID = 24'h3c_5a96;
  logic clk_sys, rst, wr_en, rd_en, align_req, tick;
  logic [6:0] addr;
  logic [7:0] wr_data, rd_data, s1;
  logic l2, l2off, synced, phase, srs;
  logic ev, reseed, beat, div2, lowf, lowp, alarm;
  logic [6:0] rw [7] = '{OFS_ALIGN_CTRL, OFS_TIMER_LOW, OFS_TIMER_HIGH,
    OFS_EXT_OSC_CTRL, OFS_DELAY_COMMON, OFS_FIRST_MASK, OFS_GENERAL_MASK};
  int err_total, n_compared, cyc;
  stam_host host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data));
  stam_regs #(.PART_ID(ID)) dut (.clk_sys(clk_sys), .rst(rst),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .align_req(align_req), .ref_zero_clk_tick(tick),
    .first_loop_count_hit(s1[7]), .first_loop_acquiring(s1[6]),
    .first_loop_locked(s1[5]), .first_loop_holdover(s1[4]),
    .input_los(s1[3:0]), .second_loop_locked(l2),
    .second_loop_disabled(l2off), .outputs_synced(synced),
    .output_phase_status(phase), .sysref_sync_status(srs),
    .rd_data(rd_data), .align_event(ev), .reseed_via_second_loop(reseed),
    .master_beat(beat), .oscillator_div2(div2),
    .oscillator_low_freq(lowf), .delay_low_power(lowp), .alarm(alarm));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("rd_data", e, d);
  endtask
  // Period is the count from one beat to the next
  task automatic gap(input int e);
    int n;
    n = 0;
    while (beat !== 1'b1 && n < 600) begin
      tk(1);
      n++;
    end
    n = 1;
    tk(1);
    while (beat !== 1'b1 && n < 600) begin
      tk(1);
      n++;
    end
    chk("beat_gap", e[15:0], n[15:0]);
  endtask
  task automatic gen(input logic [7:0] m, input logic [5:0] st,
    input logic e);
    {l2, l2off, synced, s1[5], phase, srs} = st;
    host.wr(OFS_GENERAL_MASK, m);
    tk(5);
    chk("alarm", e, alarm);
  endtask
  task automatic evs(input logic e);
    logic s;
    s = 1'b0;
    repeat (12) begin
      tk(1);
      s = s | ev;
    end
    chk("align_event", e, s);
  endtask
  initial begin
    {rst, align_req, tick, l2, l2off, phase, srs} = 7'h41;
    s1 = 8'h00;
    synced = 1'b1;
    {err_total, n_compared, cyc} = '0;
    tk(5);
    rst = 1'b0;
    foreach (rw[i]) rdc(rw[i], 8'h00);
    for (int j = 0; j < 3; j++) begin
      host.wr(OFS_PART_ID_LOW + 7'(j), 8'hff);
      rdc(OFS_PART_ID_LOW + 7'(j), ID[8*j+:8]);
    end
    host.wr(7'h60, 8'h5a);
    rdc(7'h60, 8'h00);
    host.wr(OFS_ALARM_READBACK, 8'hff);
    rdc(OFS_ALARM_READBACK, 8'h00);
    foreach (rw[i]) host.wr(rw[i], 8'hf0);
    foreach (rw[i]) rdc(rw[i], 8'hf0);
    chk("ctrl", 16'h0000, {alarm, ev, reseed, div2, lowf, lowp});
    gap(241);
    host.wr(OFS_TIMER_HIGH, 8'hf1);
    gap(497);
    host.wr(OFS_ALIGN_CTRL, 8'h02);
    host.wr(OFS_EXT_OSC_CTRL, 8'h03);
    host.wr(OFS_DELAY_COMMON, 8'h01);
    tk(1);
    chk("ctrl", 16'h000f, {reseed, div2, lowf, lowp});
    host.wr(OFS_GENERAL_MASK, 8'h00);
    for (int i = 0; i < 8; i++) begin
      s1 = 8'h01 << i;
      host.wr(OFS_FIRST_MASK, 8'h01 << i);
      tk(5);
      chk("alarm", 1'b1, alarm);
      rdc(OFS_ALARM_READBACK, 8'h01);
      host.wr(OFS_FIRST_MASK, ~(8'h01 << i));
      tk(5);
      chk("alarm", 1'b0, alarm);
    end
    s1 = 8'h00;
    host.wr(OFS_FIRST_MASK, 8'h00);
    gen(8'h10, 6'h10, 1'b1);
    gen(8'h10, 6'h28, 1'b0);
    gen(8'h08, 6'h24, 1'b1);
    gen(8'h08, 6'h28, 1'b0);
    gen(8'h04, 6'h02, 1'b1);
    gen(8'h02, 6'h01, 1'b1);
    gen(8'h01, 6'h28, 1'b1);
    gen(8'he0, 6'h17, 1'b0);
    align_req = 1'b1;
    evs(1'b1);
    host.wr(OFS_ALIGN_CTRL, 8'h03);
    align_req = 1'b0;
    evs(1'b1);
    align_req = 1'b1;
    evs(1'b0);
    align_req = 1'b0;
    evs(1'b1);
    host.wr(OFS_ALIGN_CTRL, 8'h06);
    align_req = 1'b1;
    evs(1'b0);
    tick = 1'b1;
    tk(2);
    tick = 1'b0;
    evs(1'b1);
    final_report();
  end
endmodule // tb_stam_regs
